// [pkg/emtx_pkg.sv]
package emtx_pkg;

    // Macro instruction field positions; bit 15 carries the most significant field bit.
    localparam int F_MSB = 15;
    localparam int F_LSB = 12;
    localparam int F1_MSB = 11;
    localparam int F1_LSB = 8;
    localparam int R_BIT = 7;

    localparam logic [3:0] F_ZERO = 4'h0;
    localparam logic [3:0] F1_SKIP_A = 4'h1;
    localparam logic [3:0] F1_SKIP_B = 4'h0;
    localparam logic [3:0] F1_SKIP_C = 4'h6;
    localparam logic [3:0] F1_SE_A = 4'h2;
    localparam logic [3:0] F1_SE_B = 4'h3;
    localparam logic [3:0] F1_ENH_A = 4'h4;
    localparam logic [3:0] F1_ENH_B = 4'h5;
    localparam logic [3:0] F1_INTER_REG = 4'h8;
    localparam logic [3:0] F1_INT = 4'he;

    localparam logic [15:0] DELTA_ALL_ONES = 16'hffff;
    localparam logic [15:0] DELTA_ZERO = 16'h0000;

    // Interrupt transform micro addresses.
    localparam logic [7:0] XT_MICRO_INT = 8'hbc;
    localparam logic [7:0] XT_MICRO_INT_GENUINE = 8'hbd;
    localparam logic [7:0] XT_MACRO_INT = 8'hbe;
    localparam logic [7:0] XT_MACRO_INT_GENUINE = 8'hbf;

    // APB register map, byte addresses.
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int CTRL_PROTECT_BIT = 0;
    localparam int CTRL_STEP_BIT = 1;
    localparam int STAT_IE_BIT = 0;
    localparam int STAT_PRE_BIT = 1;
    localparam int STAT_CHI_BIT = 2;
    localparam int STAT_BLK_BIT = 3;
    localparam int STAT_PV_BIT = 4;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    typedef enum logic [1:0] {
        EMTX_IE_IDLE = 2'b00,
        EMTX_IE_ARMED = 2'b01,
        EMTX_IE_WAIT_RNI = 2'b11,
        EMTX_IE_WAIT_INC = 2'b10
    } emtx_ie_e;

    // Processor operation events and levels, all on sys_clk.
    typedef struct packed {
        logic read_next_instruction_cycle;
        logic fetch_xt;
        logic pc_inc;
        logic go;
        logic t4;
        logic mem_done;
        logic preenable_set;
        logic ie_clear;
    } emtx_ops_s;

    // Interrupt detection request from the processor.
    typedef struct packed {
        logic detected;
        logic macro_sel;
        logic inhibit_pending;
        logic false_int;
    } emtx_int_s;

    typedef struct packed {
        logic [1:0] ctrl;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [15:0] delta;
        logic delta_en;
        logic fetch_d;
        logic mem_done_d;
        logic prev_prot;
        logic pv_pulse;
        logic pv_sticky;
        emtx_ie_e ie_st;
        logic pre_flag;
        logic ie_flag;
        logic ie_strobe;
        logic [7:0] xt_addr;
        logic xt_valid;
        logic dest_strobe;
        logic redirect;
        logic chi_flag;
        logic blk_n;
    } emtx_state_s;

    // Storage-reference or enhanced instruction: F is zero and it is not a skip.
    function automatic logic emtx_is_long(input logic [15:0] iw);
        logic [3:0] f1;
        f1 = iw[F1_MSB:F1_LSB];
        return (iw[F_MSB:F_LSB] == F_ZERO) && (f1 != F1_SKIP_A) && (f1 != F1_SKIP_B) && (f1 != F1_SKIP_C);
    endfunction

endpackage

// [rtl/emtx_delta.sv]
`timescale 1ns/1ps
module emtx_delta import emtx_pkg::*; (
    // Fetched macro instruction.
    input wire logic [15:0] instr,
    // Status mode qualifiers.
    input wire logic decimal_correct_flag,
    input wire logic file_output_select_flag,
    // Translated displacement.
    output logic [15:0] delta,
    output logic delta_en
);

    logic [3:0] f1;
    logic fzero;

    always_comb begin
        f1 = instr[F1_MSB:F1_LSB];
        fzero = instr[F_MSB:F_LSB] == F_ZERO;
        delta_en = !decimal_correct_flag && !file_output_select_flag && !(fzero && f1 == F1_INTER_REG); // RL6
        delta = {{8{instr[7]}}, instr[7:0]};
        if (!delta_en) begin
            delta = DELTA_ALL_ONES; // RL5
        end else if (fzero) begin
            if (f1 == F1_INT) begin
                delta = {7'h00, 1'b1, instr[7:0]}; // RL4
            end else if (f1 == F1_SKIP_A || f1 == F1_SKIP_B || f1 == F1_SKIP_C) begin
                delta = {12'h000, instr[3:0]}; // RL3
            end else if ((f1 == F1_ENH_A || f1 == F1_ENH_B) && !instr[R_BIT]) begin
                delta = DELTA_ZERO; // RL1
            end else if (f1[3] || f1 == F1_SE_A || f1 == F1_SE_B) begin
                delta = {{8{instr[7]}}, instr[7:0]}; // RL2
            end
        end
    end

endmodule

// [rtl/emtx_misc.sv]
//
// Contract
// [RL1] Enhanced F1 4/5, r zero: zero displacement.
// [RL2] F1 1xxx or 2/3: sign-extended low byte.
// [RL3] Skip instructions: low four bits, zero-filled.
// [RL4] Interrupt instructions: seven zeros, one, byte.
// [RL5] Inter-register instruction disables translator, all ones.
// [RL6] Translator enabled only with both flags clear.
// [RL7] Protected after nonprotected, or unprotected: violation. The code flags unprotected only with the protect switch set.
// [RL8] Unprotected miscellaneous with protect switch: violation.
// [RL9] Memory interface detects all other protect violations.
// [RL10] Interrupts activate one instruction after enable.
// [RL11] Firmware sets pre-enable when emulating enable.
// [RL12] Short follower: set strobe at next read.
// [RL13] Long follower: set at program-counter increment.
// [RL14] Enable flag set clears pre-enable flag.
// [RL15] Interrupt transform gives BC or BE.
// [RL16] Genuine non-inhibit interrupt gives BD or BF.
// [RL17] Destination strobed at T4, else read trailing edge.
// [RL18] Step mode fetch-transform clears clear-halt flag.
// [RL19] GO command sets the clear-halt flag.
// [RL20] Long instruction at fetch-transform drives block low.
// [RL21] Program-counter increment returns block high.
// [RL22] Master clear forces block signal high.
// [RL23] Master clear clears the pre-enable flag.
`timescale 1ns/1ps
module emtx_misc import emtx_pkg::*; (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Processor operations and fetched instruction.
    input wire emtx_ops_s ops,
    input wire logic [15:0] instr,
    input wire logic instr_protected,
    input wire logic misc_instr,
    input wire logic decimal_correct_flag,
    input wire logic file_output_select_flag,
    input wire emtx_int_s intr,
    // Displacement translator.
    output logic [15:0] delta_word,
    output logic delta_enable,
    // Protect checking.
    output logic protect_violation,
    // Interrupt enable sequencing.
    output logic interrupt_preenable_flag,
    output logic interrupt_enable_flag,
    output logic interrupt_enable_set_strobe,
    // Interrupt transform.
    output logic [7:0] interrupt_transform,
    output logic interrupt_transform_valid,
    // Destination strobe and halt control.
    output logic dest_strobe,
    output logic transform_strobe_redirect,
    output logic clear_halt_interrupt_flag,
    output logic halt_interrupt_block_n
);

    emtx_state_s st;
    emtx_state_s next_st;
    logic [15:0] xlat_delta;
    logic xlat_en;
    logic fetch_rise;
    logic apb_access;
    logic prot_sw;
    logic step_mode;
    logic pv_now;

    emtx_delta u_delta (
        .instr(instr),
        .decimal_correct_flag(decimal_correct_flag),
        .file_output_select_flag(file_output_select_flag),
        .delta(xlat_delta),
        .delta_en(xlat_en)
    );

    always_comb begin
        next_st = st;
        fetch_rise = ops.fetch_xt && !st.fetch_d;
        prot_sw = st.ctrl[CTRL_PROTECT_BIT];
        step_mode = st.ctrl[CTRL_STEP_BIT];
        apb_access = psel && penable && !st.pready;
        next_st.fetch_d = ops.fetch_xt;
        next_st.mem_done_d = ops.mem_done;

        // Displacement word is captured on every cycle from the translator.
        next_st.delta = xlat_delta; // RL1 RL2 RL3 RL4 RL5
        next_st.delta_en = xlat_en; // RL6

        // Protect checks are made as each instruction is transformed.
        pv_now = 1'b0;
        next_st.pv_pulse = 1'b0;
        if (fetch_rise) begin
            pv_now = (instr_protected && !st.prev_prot) || (!instr_protected && prot_sw); // RL7
            if (!instr_protected && misc_instr && prot_sw) begin
                pv_now = 1'b1; // RL8
            end
            next_st.prev_prot = instr_protected;
            next_st.pv_pulse = pv_now;
        end

        // Deferred interrupt enable.
        next_st.ie_strobe = 1'b0;
        case (st.ie_st)
            EMTX_IE_IDLE: begin
                if (ops.preenable_set) begin
                    next_st.ie_st = EMTX_IE_ARMED;
                end
            end
            EMTX_IE_ARMED: begin
                if (fetch_rise) begin
                    next_st.ie_st = emtx_is_long(instr) ? EMTX_IE_WAIT_INC : EMTX_IE_WAIT_RNI; // RL10
                end
            end
            EMTX_IE_WAIT_RNI: begin
                if (ops.read_next_instruction_cycle) begin
                    next_st.ie_strobe = 1'b1; // RL12
                    next_st.ie_st = EMTX_IE_IDLE;
                end
            end
            EMTX_IE_WAIT_INC: begin
                if (ops.pc_inc) begin
                    next_st.ie_strobe = 1'b1; // RL13
                    next_st.ie_st = EMTX_IE_IDLE;
                end
            end
            default: begin
                next_st.ie_st = EMTX_IE_IDLE;
            end
        endcase
        if (st.ie_strobe) begin
            next_st.pre_flag = 1'b0; // RL14
        end
        if (ops.preenable_set) begin
            next_st.pre_flag = 1'b1;
        end
        if (ops.ie_clear) begin
            next_st.ie_flag = 1'b0;
        end
        if (st.ie_strobe) begin
            next_st.ie_flag = 1'b1;
        end

        // Interrupt transform address.
        next_st.xt_valid = intr.detected;
        if (intr.detected) begin
            if (!intr.inhibit_pending && !intr.false_int) begin
                next_st.xt_addr = intr.macro_sel ? XT_MACRO_INT_GENUINE : XT_MICRO_INT_GENUINE; // RL16
            end else begin
                next_st.xt_addr = intr.macro_sel ? XT_MACRO_INT : XT_MICRO_INT; // RL15
            end
        end

        // Destination strobe moves from T4 to the read trailing edge during fetch-transform.
        next_st.redirect = ops.fetch_xt;
        if (ops.fetch_xt) begin
            next_st.dest_strobe = st.mem_done_d && !ops.mem_done; // RL17
        end else begin
            next_st.dest_strobe = ops.t4; // RL17
        end

        // Clear-halt flag and halt block.
        if (ops.go) begin
            next_st.chi_flag = 1'b1; // RL19
        end else if (fetch_rise && step_mode) begin
            next_st.chi_flag = 1'b0; // RL18
        end
        if (fetch_rise && emtx_is_long(instr)) begin
            next_st.blk_n = 1'b0; // RL20
        end else if (ops.pc_inc) begin
            next_st.blk_n = 1'b1; // RL21
        end

        // APB slave: one wait state, then a one-cycle ready.
        next_st.pready = apb_access;
        next_st.pslverr = 1'b0;
        next_st.prdata = 32'h0000_0000;
        if (st.pv_sticky || st.pv_pulse) begin
            next_st.pv_sticky = 1'b1;
        end
        if (apb_access) begin
            if (paddr == ADDR_CTRL) begin
                if (pwrite) begin
                    next_st.ctrl = pwdata[1:0];
                end else begin
                    next_st.prdata = {30'h0000_0000, st.ctrl};
                end
            end else if (paddr == ADDR_STATUS) begin
                if (pwrite) begin
                    // Write one to clear; a violation in the same cycle wins.
                    if (pwdata[STAT_PV_BIT] && !st.pv_pulse) begin
                        next_st.pv_sticky = 1'b0;
                    end
                end else begin
                    next_st.prdata = {25'h000_0000, st.ie_st, st.pv_sticky, st.blk_n,
                                      st.chi_flag, st.pre_flag, st.ie_flag};
                end
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            st <= '0;
            st.ctrl <= CTRL_RESET;
            st.ie_st <= EMTX_IE_IDLE;
            st.pre_flag <= 1'b0; // RL23
            st.blk_n <= 1'b1; // RL22
            st.delta <= DELTA_ALL_ONES;
            st.prev_prot <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign delta_word = st.delta;
    assign delta_enable = st.delta_en;
    assign protect_violation = st.pv_pulse;
    assign interrupt_preenable_flag = st.pre_flag;
    assign interrupt_enable_flag = st.ie_flag;
    assign interrupt_enable_set_strobe = st.ie_strobe;
    assign interrupt_transform = st.xt_addr;
    assign interrupt_transform_valid = st.xt_valid;
    assign dest_strobe = st.dest_strobe;
    assign transform_strobe_redirect = st.redirect;
    assign clear_halt_interrupt_flag = st.chi_flag;
    assign halt_interrupt_block_n = st.blk_n;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence s_inter_reg;
        instr[F_MSB:F_LSB] == F_ZERO && instr[F1_MSB:F1_LSB] == F1_INTER_REG;
    endsequence

    sequence s_enh_zero;
        !decimal_correct_flag && !file_output_select_flag && instr[F_MSB:F_LSB] == F_ZERO
        && (instr[F1_MSB:F1_LSB] == F1_ENH_A || instr[F1_MSB:F1_LSB] == F1_ENH_B) && !instr[R_BIT];
    endsequence

    sequence s_short_follow;
        st.ie_st == EMTX_IE_WAIT_RNI && ops.read_next_instruction_cycle;
    endsequence

    sequence s_long_follow;
        st.ie_st == EMTX_IE_WAIT_INC && ops.read_next_instruction_cycle && !ops.pc_inc;
    endsequence

    property p_enh_zero;
        s_enh_zero |=> delta_word == DELTA_ZERO && delta_enable;
    endproperty
    a_enh_zero: assert property (p_enh_zero) else $error("enhanced zero displacement wrong"); // RL1

    property p_inter_reg;
        s_inter_reg |=> delta_word == DELTA_ALL_ONES && !delta_enable;
    endproperty
    a_inter_reg: assert property (p_inter_reg) else $error("inter-register displacement not all ones"); // RL5

    property p_int_delta;
        !decimal_correct_flag && !file_output_select_flag && instr[F_MSB:F_LSB] == F_ZERO
        && instr[F1_MSB:F1_LSB] == F1_INT |=> delta_word == {7'h00, 1'b1, $past(instr[7:0])};
    endproperty
    a_int_delta: assert property (p_int_delta) else $error("interrupt displacement wrong"); // RL4

    property p_short_ie;
        s_short_follow |=> interrupt_enable_set_strobe
            ##1 (interrupt_enable_flag && (!interrupt_preenable_flag || $past(ops.preenable_set)));
    endproperty
    a_short_ie: assert property (p_short_ie) else $error("short follower did not enable at read"); // RL12

    property p_long_ie;
        s_long_follow |=> !interrupt_enable_set_strobe;
    endproperty
    a_long_ie: assert property (p_long_ie) else $error("long follower enabled too early"); // RL13

    property p_pre_clear;
        interrupt_enable_set_strobe && !ops.preenable_set |=> !interrupt_preenable_flag;
    endproperty
    a_pre_clear: assert property (p_pre_clear) else $error("pre-enable not cleared"); // RL14

    property p_xt_addr;
        intr.detected |=> interrupt_transform_valid
            && interrupt_transform[7:2] == XT_MICRO_INT[7:2]
            && interrupt_transform[1] == $past(intr.macro_sel)
            && interrupt_transform[0] == ($past(!intr.inhibit_pending) && $past(!intr.false_int));
    endproperty
    a_xt_addr: assert property (p_xt_addr) else $error("interrupt transform address wrong"); // RL16

    property p_t4_blocked;
        ops.fetch_xt && ops.t4 && !(st.mem_done_d && !ops.mem_done) |=> !dest_strobe && transform_strobe_redirect;
    endproperty
    a_t4_blocked: assert property (p_t4_blocked) else $error("T4 strobe leaked during fetch-transform"); // RL17

    property p_step_clear;
        fetch_rise && step_mode && !ops.go |=> !clear_halt_interrupt_flag;
    endproperty
    a_step_clear: assert property (p_step_clear) else $error("clear-halt flag not cleared in step"); // RL18

    property p_go_set;
        ops.go |=> clear_halt_interrupt_flag;
    endproperty
    a_go_set: assert property (p_go_set) else $error("GO did not set clear-halt flag"); // RL19

    property p_block;
        fetch_rise && emtx_is_long(instr) |=> !halt_interrupt_block_n ##1 (!halt_interrupt_block_n || $past(ops.pc_inc));
    endproperty
    a_block: assert property (p_block) else $error("halt block not asserted"); // RL20

    property p_unblock;
        ops.pc_inc && !(fetch_rise && emtx_is_long(instr)) |=> halt_interrupt_block_n;
    endproperty
    a_unblock: assert property (p_unblock) else $error("halt block not released"); // RL21

    property p_prot;
        fetch_rise && instr_protected && !st.prev_prot |=> protect_violation ##1 !protect_violation;
    endproperty
    a_prot: assert property (p_prot) else $error("protect violation missed"); // RL7

    property p_misc_prot;
        fetch_rise && !instr_protected && misc_instr && prot_sw |=> protect_violation;
    endproperty
    a_misc_prot: assert property (p_misc_prot) else $error("miscellaneous protect violation missed"); // RL8

endmodule

// [testbench/emtx_cpu_model.sv]
`timescale 1ns/1ps
module emtx_cpu_model import emtx_pkg::*; (
    // Clock.
    input wire logic sys_clk,
    // Processor side of the block.
    output emtx_ops_s ops,
    output logic [15:0] instr,
    output logic instr_protected,
    output logic misc_instr,
    output emtx_int_s intr
);
    initial begin
        ops = '0;
        instr = 16'h0000;
        instr_protected = 1'b1;
        misc_instr = 1'b0;
        intr = '0;
    end
    // Store protect faults belong to the memory side and are never shown here.
    task automatic word(input logic [15:0] w, input logic p, input logic m);
        @(posedge sys_clk);
        instr <= w;
        instr_protected <= p;
        misc_instr <= m;
    endtask
    task automatic fetch(input logic [15:0] w, input logic p, input logic m);
        word(w, p, m);
        ops.fetch_xt <= 1'b1;
    endtask
    task automatic fetch_end;
        @(posedge sys_clk);
        ops.fetch_xt <= 1'b0;
    endtask
    // One-cycle operation pulses; firmware emulating enable-interrupt raises preenable_set.
    task automatic pulse(input logic [7:0] o);
        @(posedge sys_clk);
        ops <= emtx_ops_s'(ops | o);
        @(posedge sys_clk);
        ops <= emtx_ops_s'(ops & ~o);
    endtask
    task automatic irq(input logic m, input logic inh, input logic f);
        @(posedge sys_clk);
        intr <= {1'b1, m, inh, f};
        @(posedge sys_clk);
        intr.detected <= 1'b0;
    endtask
endmodule

// [testbench/emtx_misc_tb.sv]
`timescale 1ns/1ps
module emtx_misc_tb import emtx_pkg::*;;
    typedef struct {int id; logic [31:0] v;} emtx_note_s;
    localparam int DW = 0, DE = 1, PV = 2, PRE = 3, IE = 4, STB = 5, XT = 6;
    localparam int DS = 7, RED = 8, CHI = 9, BLK = 10, RD = 11, ERR = 12;
    localparam logic [7:0] P_RNI = 8'h80, P_INC = 8'h20, P_GO = 8'h10, P_T4 = 8'h08;
    localparam logic [7:0] P_MEM = 8'h04, P_PRE = 8'h02, P_CLR = 8'h01;
    localparam logic [3:0] F1S [12] = '{4'h4, 4'h4, 4'h5, 4'h2, 4'h3, 4'h9, 4'hc, 4'h1, 4'h0, 4'h6, 4'he, 4'h8};
    logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, rd_e;
    logic [7:0] paddr, interrupt_transform;
    logic [31:0] pwdata, prdata, rd_d;
    logic [15:0] instr, delta_word, w;
    logic instr_protected, misc_instr, decimal_correct_flag, file_output_select_flag, delta_enable;
    logic protect_violation, interrupt_preenable_flag, interrupt_enable_flag, interrupt_enable_set_strobe;
    logic interrupt_transform_valid, dest_strobe, transform_strobe_redirect, clear_halt_interrupt_flag;
    logic halt_interrupt_block_n;
    emtx_ops_s ops;
    emtx_int_s intr;
    emtx_note_s exp_q[$];
    emtx_note_s n;
    logic [31:0] got;
    int failures = 0;
    int checks_done = 0;

    emtx_misc u_emtx_misc (.sys_clk(sys_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ops(ops),
        .instr(instr), .instr_protected(instr_protected), .misc_instr(misc_instr),
        .decimal_correct_flag(decimal_correct_flag), .file_output_select_flag(file_output_select_flag),
        .intr(intr), .delta_word(delta_word), .delta_enable(delta_enable), .protect_violation(protect_violation),
        .interrupt_preenable_flag(interrupt_preenable_flag), .interrupt_enable_flag(interrupt_enable_flag),
        .interrupt_enable_set_strobe(interrupt_enable_set_strobe), .interrupt_transform(interrupt_transform),
        .interrupt_transform_valid(interrupt_transform_valid), .dest_strobe(dest_strobe),
        .transform_strobe_redirect(transform_strobe_redirect),
        .clear_halt_interrupt_flag(clear_halt_interrupt_flag), .halt_interrupt_block_n(halt_interrupt_block_n));
    emtx_cpu_model u_emtx_cpu_model (.sys_clk(sys_clk), .ops(ops), .instr(instr),
        .instr_protected(instr_protected), .misc_instr(misc_instr), .intr(intr));

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] obs(input int id);
        case (id)
            DW: return {16'h0, delta_word};
            DE: return {31'h0, delta_enable};
            PV: return {31'h0, protect_violation};
            PRE: return {31'h0, interrupt_preenable_flag};
            IE: return {31'h0, interrupt_enable_flag};
            STB: return {31'h0, interrupt_enable_set_strobe};
            XT: return {23'h0, interrupt_transform_valid, interrupt_transform};
            DS: return {31'h0, dest_strobe};
            RED: return {31'h0, transform_strobe_redirect};
            CHI: return {31'h0, clear_halt_interrupt_flag};
            BLK: return {31'h0, halt_interrupt_block_n};
            RD: return rd_d;
            default: return {31'h0, rd_e};
        endcase
    endfunction

    // Expected displacement, worked out independently of the design.
    function automatic logic [15:0] xl(input logic [15:0] iw);
        logic [15:0] se;
        se = {{8{iw[7]}}, iw[7:0]};
        if (iw[15:12] != 4'h0) return se;
        case (iw[11:8])
            4'h8: return 16'hffff;
            4'h4, 4'h5: return iw[7] ? se : 16'h0000;
            4'h0, 4'h1, 4'h6: return {12'h000, iw[3:0]};
            4'he: return {7'h00, 1'b1, iw[7:0]};
            default: return se;
        endcase
    endfunction

    task automatic chk(input int id, input logic [31:0] v);
        exp_q.push_back('{id, v});
    endtask

    task automatic results;
        $display("checks_done %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd_d = prdata;
        rd_e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Full fetch-transform: violation check, then t4 ignored and the read trailing edge strobing.
    task automatic fx(input logic [15:0] iw, input logic p, input logic m, input logic pv_exp);
        u_emtx_cpu_model.fetch(iw, p, m);
        @(posedge sys_clk);
        #1;
        chk(PV, {31'h0, pv_exp});
        chk(RED, 32'h1);
        u_emtx_cpu_model.pulse(P_T4 | P_MEM);
        #1;
        chk(DS, 32'h0);
        @(posedge sys_clk);
        #1;
        chk(DS, 32'h1);
        u_emtx_cpu_model.fetch_end();
        @(posedge sys_clk);
        #1;
        chk(RED, 32'h0);
    endtask

    initial begin
        forever begin
            wait (exp_q.size() != 0);
            n = exp_q.pop_front();
            got = obs(n.id);
            checks_done++;
            if (got !== n.v) begin
                failures++;
                $display("CHECK FAILED t=%0t id=%0d got=%h exp=%h", $time, n.id, got, n.v);
            end
        end
    end

    initial begin
        #20000;
        failures++;
        results();
    end

    initial begin
        void'($urandom(85));
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        decimal_correct_flag = 1'b0;
        file_output_select_flag = 1'b0;
        repeat (3) @(posedge sys_clk);
        #1;
        chk(DW, 32'hffff);
        chk(BLK, 32'h1);
        chk(PRE, 32'h0);
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(RD, 32'h1 << STAT_BLK_BIT);
        chk(ERR, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'hffffffff);
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(RD, 32'h3);
        apb(1'b1, 8'h10, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        chk(RD, 32'h0);
        chk(ERR, 32'h1);
        $display("test registers done");
        for (int i = 0; i < 12; i++) begin
            w = {4'h0, F1S[i], 8'($urandom)};
            w[7] = (i == 0) ? 1'b0 : (i == 1) ? 1'b1 : w[7];
            u_emtx_cpu_model.word(w, 1'b1, 1'b0);
            @(posedge sys_clk);
            #1;
            chk(DW, {16'h0, xl(w)});
            chk(DE, {31'h0, F1S[i] != 4'h8});
        end
        u_emtx_cpu_model.word(16'h1234, 1'b1, 1'b0);
        for (int j = 1; j < 3; j++) begin
            @(posedge sys_clk);
            {file_output_select_flag, decimal_correct_flag} <= 2'(j);
            @(posedge sys_clk);
            #1;
            chk(DE, 32'h0);
        end
        @(posedge sys_clk);
        {file_output_select_flag, decimal_correct_flag} <= 2'h0;
        $display("test translator done");
        apb(1'b1, ADDR_CTRL, 32'h1);
        fx(16'h1234, 1'b0, 1'b0, 1'b1);
        fx(16'h1234, 1'b1, 1'b0, 1'b1);
        fx(16'h1234, 1'b1, 1'b0, 1'b0);
        fx(16'h1234, 1'b0, 1'b1, 1'b1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(RD, 32'h18);
        apb(1'b1, ADDR_STATUS, 32'h10);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk(RD, 32'h8);
        apb(1'b1, ADDR_CTRL, 32'h0);
        fx(16'h1234, 1'b0, 1'b0, 1'b0);
        fx(16'h1234, 1'b1, 1'b0, 1'b1);
        $display("test protect done");
        u_emtx_cpu_model.pulse(P_PRE);
        #1;
        chk(PRE, 32'h1);
        fx(16'h0100, 1'b1, 1'b0, 1'b0);
        chk(IE, 32'h0);
        u_emtx_cpu_model.pulse(P_RNI);
        #1;
        chk(STB, 32'h1);
        @(posedge sys_clk);
        #1;
        chk(IE, 32'h1);
        chk(PRE, 32'h0);
        u_emtx_cpu_model.pulse(P_CLR);
        u_emtx_cpu_model.pulse(P_PRE);
        fx(16'h0400, 1'b1, 1'b0, 1'b0);
        chk(BLK, 32'h0);
        u_emtx_cpu_model.pulse(P_RNI);
        #1;
        chk(STB, 32'h0);
        chk(IE, 32'h0);
        u_emtx_cpu_model.pulse(P_INC);
        #1;
        chk(STB, 32'h1);
        chk(BLK, 32'h1);
        @(posedge sys_clk);
        #1;
        chk(IE, 32'h1);
        chk(PRE, 32'h0);
        $display("test interrupt enable done");
        for (int i = 0; i < 8; i++) begin
            u_emtx_cpu_model.irq(i[2], i[1], i[0]);
            #1;
            chk(XT, {24'h1, 6'b101111, i[2], !i[1] && !i[0]});
        end
        $display("test transform done");
        apb(1'b1, ADDR_CTRL, 32'h2);
        u_emtx_cpu_model.pulse(P_GO);
        #1;
        chk(CHI, 32'h1);
        fx(16'h0100, 1'b1, 1'b0, 1'b0);
        chk(CHI, 32'h0);
        u_emtx_cpu_model.pulse(P_T4);
        #1;
        chk(DS, 32'h1);
        u_emtx_cpu_model.pulse(P_PRE);
        fx(16'h0500, 1'b1, 1'b0, 1'b0);
        @(posedge sys_clk);
        reset <= 1'b1;
        #1;
        chk(BLK, 32'h1);
        chk(PRE, 32'h0);
        @(posedge sys_clk);
        reset <= 1'b0;
        $display("test halt and clear done");
        wait (exp_q.size() == 0);
        #1;
        results();
    end
endmodule
